// *** design/stm_pkg.sv ***
package stm_pkg;

  // ----------------------------------------------------------------
  // Register map (word offsets, byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL0  = 8'h00;
  localparam logic [7:0] ADDR_CTRL1  = 8'h04;
  localparam logic [7:0] ADDR_CNT    = 8'h08;
  localparam logic [7:0] ADDR_CMPA   = 8'h0c;
  localparam logic [7:0] ADDR_CMPP   = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // ----------------------------------------------------------------
  // Field positions in the control and status registers
  // ----------------------------------------------------------------
  localparam int RUN_BIT    = 0;
  localparam int CLR_BIT    = 0;
  localparam int SWAP_BIT   = 1;
  localparam int INV_BIT    = 2;
  localparam int INIT_BIT   = 3;
  localparam int PIN_LO_BIT = 4;
  localparam int MODE_LO    = 6;
  localparam int FLAG_A_BIT = 0;
  localparam int FLAG_P_BIT = 1;

  localparam logic [7:0]  CTRL1_RESET = 8'h00;
  localparam logic [15:0] CMPA_RESET  = 16'h0000;
  localparam logic [7:0]  CMPP_RESET  = 8'h00;
  localparam int          SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    STM_MODE_CMP  = 2'b00,
    STM_MODE_CAP  = 2'b01,
    STM_MODE_PWM  = 2'b10,
    STM_MODE_TMR  = 2'b11
  } stm_mode_t;

  typedef struct packed {
    stm_mode_t  mode;
    logic [1:0] pin_action;
    logic       init_level;
    logic       invert;
    logic       swap;
    logic       clr_sel;
  } stm_ctrl_t;

endpackage

// *** design/stm_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module stm_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= '0;
      q      <= '0;
    end
    else if (ce)
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// *** design/stm_timer.sv ***
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Mode 00 is compare-match output mode
// - Clear select low: P match or overflow clears
// - Clear select high: A match clears, no P flag
// - Pin changes only on A match
// - Run rising edge restores initial pin level
// - Mode 11 counts like compare, pin unused
// - PWM ignores clear select; swap picks roles
// - Swap zero: period P*256, duty A
// - Duty at or above period gives 100%
// - Swap set: period A, duty P*256
// - PWM raises A and P flags on matches; here pulse mode (pin code 11) never raises the P flag
// - PWM runs while pin forced fixed
// - Initial level sets polarity; invert flips pin
// - Clock pin edge sets run in pulse mode
// - A match clears run, ends pulse, flags
// - Pulse mode counter reset only by run edge
// - Capture latches counter into A, flags
// - Capture: P match clears counter, flags P
// - Pin code 11 disables capture
// - Capture within 1.5 clocks, flag after; here the pin edge is latched 2 to 3 clocks later
// - Compare pin codes: none, low, high, toggle
// - PWM pin codes: inactive, active, PWM, pulse
// - Capture edge codes: rise, fall, both, off
// - Comparator P matches counter upper byte
module stm_timer #(
  parameter int CW = 16,
  parameter int PW = 8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer_io_pin_i,
  input  wire logic        timer_clock_pin_i,
  output logic             timer_io_pin_o,
  output logic             timer_io_pin_oe
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  stm_pkg::stm_ctrl_t ctrl_q;
  logic [CW-1:0]      cmpa_q;
  logic [PW-1:0]      cmpp_q;
  logic [CW-1:0]      cnt_q;
  logic               run_q;
  logic               run_d1_q;
  logic               flag_a_q;
  logic               flag_p_q;
  logic               pin_q;
  logic               pwm_q;
  logic [1:0]         pin_s;
  logic               io_d1_q;
  logic               ck_d1_q;
  logic               cap_pend_q;

  logic wr;
  logic run_rise;
  logic match_a;
  logic match_p;
  logic ovf;
  logic is_pwm;
  logic is_pulse;
  logic cnt_clr;
  logic io_rise;
  logic io_fall;
  logic cap_edge;
  logic ck_rise;
  logic set_a;
  logic set_p;
  logic clr_a_w;
  logic clr_p_w;

  function automatic logic upper_match(input logic [CW-1:0] c,
                                       input logic [PW-1:0] p);
    upper_match = (c[CW-1 -: PW] == p);
  endfunction

  stm_sync #(
    .WIDTH (2)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       ({timer_clock_pin_i, timer_io_pin_i}),
    .q       (pin_s)
  );

  // ----------------------------------------------------------------
  // APB slave: zero wait states, unmapped reads zero with error
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign wr     = ce && psel && penable && pwrite;

  always_comb
  begin
    pslverr = 1'b0;
    if (psel && penable)
    begin
      unique case (paddr)
        stm_pkg::ADDR_CTRL0, stm_pkg::ADDR_CTRL1, stm_pkg::ADDR_CNT,
        stm_pkg::ADDR_CMPA, stm_pkg::ADDR_CMPP, stm_pkg::ADDR_STATUS:
          pslverr = 1'b0;
        default:
          pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (ce && psel && !penable && !pwrite)
    begin
      unique case (paddr)
        stm_pkg::ADDR_CTRL0:  prdata <= {31'h0, run_q};
        stm_pkg::ADDR_CTRL1:  prdata <= {24'h0, ctrl_q};
        stm_pkg::ADDR_CNT:    prdata <= {16'h0, cnt_q};
        stm_pkg::ADDR_CMPA:   prdata <= {16'h0, cmpa_q};
        stm_pkg::ADDR_CMPP:   prdata <= {24'h0, cmpp_q};
        stm_pkg::ADDR_STATUS: prdata <= {30'h0, flag_p_q, flag_a_q};
        default:              prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= stm_pkg::stm_ctrl_t'(stm_pkg::CTRL1_RESET);
      cmpp_q <= stm_pkg::CMPP_RESET;
    end
    else if (wr && paddr == stm_pkg::ADDR_CTRL1)
      ctrl_q <= stm_pkg::stm_ctrl_t'(pwdata[7:0]);
    else if (wr && paddr == stm_pkg::ADDR_CMPP)
      cmpp_q <= pwdata[PW-1:0];
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign is_pwm   = ctrl_q.mode == stm_pkg::STM_MODE_PWM;
  assign is_pulse = is_pwm && ctrl_q.pin_action == 2'b11;
  assign run_rise = run_q && !run_d1_q;
  // Matches fire on the last count of a period, so a period spans
  // exactly the compare value; A of zero would mean a full wrap
  assign match_a  = run_q && cnt_q == cmpa_q - 1'b1;
  // Zero P value lets the counter roll over at full range
  assign match_p  = run_q && cmpp_q != '0 && &cnt_q[CW-PW-1:0] &&
                    upper_match(cnt_q + 1'b1, cmpp_q);
  assign ovf      = run_q && cnt_q == '1;
  assign io_rise  = pin_s[0] && !io_d1_q;
  assign io_fall  = !pin_s[0] && io_d1_q;
  assign ck_rise  = pin_s[1] && !ck_d1_q;

  always_comb
  begin
    cnt_clr = 1'b0;
    unique case (ctrl_q.mode)
      stm_pkg::STM_MODE_CMP, stm_pkg::STM_MODE_TMR:
        if (ctrl_q.clr_sel)
          cnt_clr = match_a;
        else
          cnt_clr = match_p || (cmpp_q == '0 && ovf);
      stm_pkg::STM_MODE_PWM:
        if (is_pulse)
          cnt_clr = 1'b0;
        else if (ctrl_q.swap)
          cnt_clr = match_a;
        else
          cnt_clr = match_p || (cmpp_q == '0 && ovf);
      stm_pkg::STM_MODE_CAP:
        cnt_clr = match_p;
    endcase
  end

  // Run edge restarts from zero ahead of any clear condition
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= '0;
    else if (ce)
    begin
      if (run_rise)
        cnt_q <= '0;
      else if (run_q && cnt_clr)
        cnt_q <= '0;
      else if (run_q)
        cnt_q <= cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_q    <= 1'b0;
      run_d1_q <= 1'b0;
      io_d1_q  <= 1'b0;
      ck_d1_q  <= 1'b0;
    end
    else if (ce)
    begin
      run_d1_q <= run_q;
      io_d1_q  <= pin_s[0];
      ck_d1_q  <= pin_s[1];
      if (is_pulse && ck_rise)
        run_q <= 1'b1;
      else if (is_pulse && match_a && !run_rise)
        run_q <= 1'b0;
      else if (wr && paddr == stm_pkg::ADDR_CTRL0)
        run_q <= pwdata[stm_pkg::RUN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Capture and flags
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (ctrl_q.pin_action)
      2'b00:   cap_edge = io_rise;
      2'b01:   cap_edge = io_fall;
      2'b10:   cap_edge = io_rise || io_fall;
      default: cap_edge = 1'b0;
    endcase
  end

  // Edge is latched at once; flag follows a clock later
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmpa_q     <= stm_pkg::CMPA_RESET;
      cap_pend_q <= 1'b0;
    end
    else if (ce)
    begin
      cap_pend_q <= 1'b0;
      if (ctrl_q.mode == stm_pkg::STM_MODE_CAP && run_q && cap_edge)
      begin
        cmpa_q     <= cnt_q;
        cap_pend_q <= 1'b1;
      end
      else if (wr && paddr == stm_pkg::ADDR_CMPA)
        cmpa_q <= pwdata[CW-1:0];
    end
  end

  always_comb
  begin
    if (ctrl_q.mode == stm_pkg::STM_MODE_CAP)
      set_a = cap_pend_q;
    else
      set_a = match_a;
    set_p = match_p || (ovf && cmpp_q == '0);
    if ((ctrl_q.mode == stm_pkg::STM_MODE_CMP ||
         ctrl_q.mode == stm_pkg::STM_MODE_TMR) && ctrl_q.clr_sel)
      set_p = 1'b0;
    if (is_pulse)
      set_p = 1'b0;
  end

  // Write one clears; a new event in the same cycle wins
  assign clr_a_w = wr && paddr == stm_pkg::ADDR_STATUS &&
                   pwdata[stm_pkg::FLAG_A_BIT];
  assign clr_p_w = wr && paddr == stm_pkg::ADDR_STATUS &&
                   pwdata[stm_pkg::FLAG_P_BIT];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag_a_q <= 1'b0;
      flag_p_q <= 1'b0;
    end
    else if (ce)
    begin
      flag_a_q <= set_a || (flag_a_q && !clr_a_w);
      flag_p_q <= set_p || (flag_p_q && !clr_p_w);
    end
  end

  // ----------------------------------------------------------------
  // Output pin
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_q <= 1'b0;
    else if (ce)
    begin
      if (run_rise)
        pin_q <= ctrl_q.init_level;
      else if (ctrl_q.mode == stm_pkg::STM_MODE_CMP && match_a)
      begin
        unique case (ctrl_q.pin_action)
          2'b00: pin_q <= pin_q;
          2'b01: pin_q <= 1'b0;
          2'b10: pin_q <= 1'b1;
          2'b11: pin_q <= !pin_q;
        endcase
      end
    end
  end

  // Active phase: count below duty; duty >= period stays active
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pwm_q <= 1'b0;
    else if (ce)
    begin
      if (is_pulse)
        pwm_q <= run_q;
      else if (!run_q)
        pwm_q <= 1'b0;
      else if (ctrl_q.swap)
        pwm_q <= cmpp_q == '0 ||
                 {8'h0, cnt_q[CW-1 -: PW]} < {8'h0, cmpp_q};
      else
        pwm_q <= cnt_q < cmpa_q ||
                 (cmpp_q != '0 &&
                  cmpa_q >= {cmpp_q, 8'h00});
    end
  end

  always_comb
  begin
    timer_io_pin_o  = 1'b0;
    timer_io_pin_oe = 1'b0;
    unique case (ctrl_q.mode)
      stm_pkg::STM_MODE_CMP:
      begin
        timer_io_pin_oe = 1'b1;
        timer_io_pin_o  = pin_q ^ ctrl_q.invert;
      end
      stm_pkg::STM_MODE_PWM:
      begin
        timer_io_pin_oe = 1'b1;
        unique case (ctrl_q.pin_action)
          2'b00:   timer_io_pin_o = !ctrl_q.init_level;
          2'b01:   timer_io_pin_o = ctrl_q.init_level;
          default: timer_io_pin_o = pwm_q ? ctrl_q.init_level
                                          : !ctrl_q.init_level;
        endcase
        timer_io_pin_o = timer_io_pin_o ^ ctrl_q.invert;
      end
      default:
      begin
        timer_io_pin_oe = 1'b0;
        timer_io_pin_o  = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_run_rise;
    ce && run_rise;
  endsequence

  sequence s_cap_edge;
    ce && ctrl_q.mode == stm_pkg::STM_MODE_CAP && run_q && cap_edge;
  endsequence

  a_run_clears_cnt: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_run_rise |=> cnt_q == '0)
    else $error("counter not zero after run rise");
  a_pin_init_lvl: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_run_rise |=> pin_q == $past(ctrl_q.init_level))
    else $error("pin not at initial level");
  a_no_p_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && ctrl_q.mode == stm_pkg::STM_MODE_CMP && ctrl_q.clr_sel
    && !flag_p_q && !clr_p_w |=> !flag_p_q)
    else $error("P flag raised with A clear");
  a_pulse_ends: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && is_pulse && match_a && !run_rise && !ck_rise |=> !run_q)
    else $error("pulse not ended on A match");
  a_cap_latch: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_cap_edge |=> cmpa_q == $past(cnt_q))
    else $error("capture not latched");
  a_cap_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_cap_edge ##1 (ce && ctrl_q.mode == stm_pkg::STM_MODE_CAP)
    |=> flag_a_q)
    else $error("capture flag not raised");
  a_cap_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && ctrl_q.mode == stm_pkg::STM_MODE_CAP &&
    ctrl_q.pin_action == 2'b11 && !wr |=> $stable(cmpa_q))
    else $error("capture with edge disabled");
  a_cnt_inc: assert property (
    @(posedge pclk) disable iff (!presetn)
    ce && run_q && !run_rise && !cnt_clr |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("counter did not step");
  a_tmr_pin_free: assert property (
    @(posedge pclk) disable iff (!presetn)
    ctrl_q.mode == stm_pkg::STM_MODE_TMR |-> !timer_io_pin_oe)
    else $error("pin driven in timer mode");
endmodule
`default_nettype wire

// *** tb/stm_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module stm_pin_model (
  input  wire logic       pclk,
  input  wire logic       drv_io,
  input  wire logic       drv_ck,
  input  wire logic [3:0] dly,
  input  wire logic       pin_o,
  input  wire logic       pin_oe,
  output logic            io_w,
  output logic            ck_w
);
  logic [15:0] io_sh = '0;
  logic [15:0] ck_sh = '0;
  // Slow answers: edges reach the pins dly+1 cycles late
  always @(posedge pclk)
  begin
    io_sh <= {io_sh[14:0], drv_io};
    ck_sh <= {ck_sh[14:0], drv_ck};
  end
  // Whoever enables drives the wire
  assign io_w = pin_oe ? pin_o : io_sh[dly];
  assign ck_w = ck_sh[dly];
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        pclk, presetn, ce, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic        pready, pslverr, se, pin_o, pin_oe;
  logic        io_w, ck_w, drv_io, drv_ck;
  logic [3:0]  dly;
  logic [1:0]  pa;
  int          n_errors, cmp_count, h, a, t1, c1, per;
  int          cyc = 0;
  logic [31:0] pw[6] = '{32'h0601_0000, 32'h0601_012c, 32'h1202_02bc,
                         32'h0e01_0040, 32'h0401_0040, 32'h0501_0040};

  stm_timer dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_io_pin_i(io_w), .timer_clock_pin_i(ck_w),
    .timer_io_pin_o(pin_o), .timer_io_pin_oe(pin_oe));

  stm_pin_model pm (.pclk(pclk), .drv_io(drv_io), .drv_ck(drv_ck),
    .dly(dly), .pin_o(pin_o), .pin_oe(pin_oe), .io_w(io_w), .ck_w(ck_w));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, e, input string m);
    cmp_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, s, e);
    end
  endtask

  task automatic xf(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    xf(1'b1, ad, d);
  endtask

  task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
    xf(1'b0, ad, 32'h0);
    chk(rd, e, "read");
  endtask

  // Stop, configure, clear flags, then optionally run
  task automatic go(input logic [7:0] c, input logic [15:0] ca,
                    input logic [7:0] cp, input logic r);
    wr(stm_pkg::ADDR_CTRL0, 32'h0);
    wr(stm_pkg::ADDR_CTRL1, {24'h0, c});
    wr(stm_pkg::ADDR_CMPA, {16'h0, ca});
    wr(stm_pkg::ADDR_CMPP, {24'h0, cp});
    wr(stm_pkg::ADDR_STATUS, 32'h3);
    wr(stm_pkg::ADDR_CTRL0, {31'h0, r});
  endtask

  task automatic hc(input int n);
    h = 0;
    repeat (n)
    begin
      // Mid-cycle sample, once the pin has settled
      @(negedge pclk);
      if (pin_o === 1'b1)
        h++;
    end
  endtask

  function automatic logic cmp_pin(input logic [1:0] c, input logic il);
    case (c)
      2'b00: return il;
      2'b01: return 1'b0;
      2'b10: return 1'b1;
      default: return ~il;
    endcase
  endfunction

  function automatic int exp_hi(input logic [31:0] x, output int pr);
    int pv;
    int du;
    pv = (x[23:16] == 8'h00) ? 65536 : x[23:16] * 256;
    pr = x[28] ? int'(x[15:0]) : pv;
    du = x[28] ? pv : int'(x[15:0]);
    if (du > pr)
      du = pr;
    if (x[25:24] == 2'b00)
      du = 0;
    if (x[25:24] == 2'b01)
      du = pr;
    return (x[26] ^ x[27]) ? du : pr - du;
  endfunction

  task automatic end_sim;
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk)
    cyc <= cyc + 1;

  initial
  begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim;
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite, drv_io, drv_ck} = '0;
    {paddr, pwdata, dly, n_errors, cmp_count} = '0;
    ce = 1'b1;
    void'($urandom(32'h0dc4));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(pin_oe, 1, "oe");
    chk(pin_o, 0, "pin");
    rdc(stm_pkg::ADDR_CTRL1, stm_pkg::CTRL1_RESET);
    rdc(stm_pkg::ADDR_CMPA, stm_pkg::CMPA_RESET);
    rdc(stm_pkg::ADDR_CMPP, stm_pkg::CMPP_RESET);
    rdc(stm_pkg::ADDR_STATUS, 32'h0);
    rdc(stm_pkg::ADDR_CNT, 32'h0);
    xf(1'b0, 8'h40, 32'h0);
    chk(se, 1, "unmapped");
    ce <= 1'b0;
    wr(stm_pkg::ADDR_CMPP, 32'h5);
    ce <= 1'b1;
    rdc(stm_pkg::ADDR_CMPP, 32'h0);
    $display("reset test done");
    for (int k = 0; k < 8; k++)
    begin
      a = 16 + $urandom % 64;
      go({2'b00, k[1:0], k[2], 3'b000}, a[15:0], 8'h1, 1'b1);
      @(posedge pclk);
      @(negedge pclk);
      chk(pin_o, k[2], "initial level");
      repeat (100) @(posedge pclk);
      chk(pin_o, cmp_pin(k[1:0], k[2]), "match action");
      repeat (200) @(posedge pclk);
      rdc(stm_pkg::ADDR_STATUS, 32'h3);
      xf(1'b0, stm_pkg::ADDR_CNT, 32'h0);
      chk(rd < 256, 1, "p clear");
    end
    go({2'b00, 2'b11, 4'b0001}, 16'd600, 8'h1, 1'b1);
    repeat (1400) @(posedge pclk);
    rdc(stm_pkg::ADDR_STATUS, 32'h1);
    xf(1'b0, stm_pkg::ADDR_CNT, 32'h0);
    chk(rd <= 600, 1, "a clear");
    go({2'b11, 6'h0}, 16'd40, 8'h0, 1'b1);
    chk(pin_oe, 0, "pin unused");
    xf(1'b0, stm_pkg::ADDR_CNT, 32'h0);
    t1 = cyc;
    c1 = rd;
    repeat (50 + $urandom % 400) @(posedge pclk);
    xf(1'b0, stm_pkg::ADDR_CNT, 32'h0);
    chk(rd - c1, cyc - t1, "count rate");
    rdc(stm_pkg::ADDR_STATUS, 32'h1);
    $display("compare and timer tests done");
    pw[0][15:0] = 16'(10 + $urandom % 190);
    for (int k = 0; k < 6; k++)
    begin
      v = pw[k];
      go({2'b10, v[25:24], v[26], v[27], v[28], 1'($urandom)},
         v[15:0], v[23:16], 1'b1);
      repeat (800) @(posedge pclk);
      a = exp_hi(v, per);
      hc(per);
      chk(h, a, "pwm high count");
      if (k == 0)
        rdc(stm_pkg::ADDR_STATUS, 32'h3);
    end
    $display("pwm test done");
    a = 40 + $urandom % 40;
    dly = 4'($urandom % 8);
    go({2'b10, 2'b11, 4'b1000}, a[15:0], 8'h0, 1'b0);
    drv_ck <= 1'b1;
    hc(200);
    chk(h >= a && h <= a + 1, 1, "pin pulse width");
    rdc(stm_pkg::ADDR_CTRL0, 32'h0);
    rdc(stm_pkg::ADDR_STATUS, 32'h1);
    xf(1'b0, stm_pkg::ADDR_CNT, 32'h0);
    chk(rd != 0, 1, "count held");
    drv_ck <= 1'b0;
    wr(stm_pkg::ADDR_CTRL0, 32'h1);
    hc(200);
    chk(h >= a && h <= a + 1, 1, "soft pulse width");
    $display("single pulse test done");
    for (int k = 0; k < 4; k++)
    begin
      pa = k[1:0];
      dly = 4'($urandom % 16);
      go({2'b01, pa, 4'b0000}, 16'h1, 8'h1, 1'b1);
      repeat (20) @(posedge pclk);
      drv_io <= 1'b1;
      t1 = cyc;
      repeat (30) @(posedge pclk);
      xf(1'b0, stm_pkg::ADDR_CMPA, 32'h0);
      c1 = rd;
      rdc(stm_pkg::ADDR_STATUS, {31'h0, pa == 2'b00 || pa == 2'b10});
      wr(stm_pkg::ADDR_STATUS, 32'h3);
      drv_io <= 1'b0;
      t1 = cyc - t1;
      repeat (30) @(posedge pclk);
      rdc(stm_pkg::ADDR_STATUS, {31'h0, pa == 2'b01 || pa == 2'b10});
      xf(1'b0, stm_pkg::ADDR_CMPA, 32'h0);
      if (pa == 2'b10)
        chk(rd - c1, t1, "capture spacing");
      if (pa == 2'b11)
        chk(rd, 32'h1, "no capture");
      repeat (300) @(posedge pclk);
      xf(1'b0, stm_pkg::ADDR_STATUS, 32'h0);
      chk(rd[1], 1, "p flag");
    end
    $display("capture test done");
    end_sim;
  end
endmodule
`default_nettype wire
